/* File: hw/tpg_pkg.sv */
// Shared constants of the pulse generator and capture timer.
// Assumes a 32-bit APB slave at byte addresses, one word per register.
package tpg_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_OUTC = 8'h04;
    localparam logic [7:0] ADDR_CAPC = 8'h08;
    localparam logic [7:0] ADDR_PRESC = 8'h0c;
    localparam logic [7:0] ADDR_COUNT = 8'h10;
    localparam logic [7:0] ADDR_CMPA = 8'h14;
    localparam logic [7:0] ADDR_CMPB = 8'h18;

    // Mode field values
    localparam logic [1:0] MODE_STOP = 2'b00;
    localparam logic [1:0] MODE_FREE = 2'b01;
    localparam logic [1:0] MODE_EDGE_CLR = 2'b10;
    localparam logic [1:0] MODE_MATCH_CLR = 2'b11;

    // Field positions in mode_ctrl_reg
    localparam int MODE_OVF_BIT = 0;
    localparam int MODE_LO_BIT = 2;
    localparam int MODE_HI_BIT = 3;

    // Field positions in output_ctrl_reg
    localparam int OUT_EN_BIT = 0;
    localparam int TOG_A_BIT = 1;
    localparam int LVL_CLR_BIT = 2;
    localparam int LVL_SET_BIT = 3;
    localparam int TOG_B_BIT = 4;
    localparam int OS_EN_BIT = 5;
    localparam int OS_TRIG_BIT = 6;

    // Field positions in capture control register
    localparam int A_CAP_BIT = 0;
    localparam int A_OPP_BIT = 1;
    localparam int B_CAP_BIT = 2;

    // Field positions in prescale_reg
    localparam int ES_A_LO = 4;
    localparam int ES_B_LO = 6;
    localparam int DIV_LO = 8;

    // Writable bits, reset values and the counter maximum
    localparam logic [7:0] MODE_WMASK = 8'h0c;
    localparam logic [7:0] OUTC_WMASK = 8'h3f;
    localparam logic [7:0] CAPC_WMASK = 8'h07;
    localparam logic [15:0] PRESC_WMASK = 16'hfff0;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;

endpackage

/* File: hw/tpg_edge_sync.sv */
// Pin synchroniser and edge detector for one timer input pin.
// Assumes the pin is asynchronous to core_clk_in.
`timescale 1ns/1ps
module tpg_edge_sync
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Pin
    input wire logic pin_in,
    // One-cycle edge pulses
    output logic rise_out,
    output logic fall_out
);
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic primed;
    logic agree;

    assign agree = (s2 == s3);

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            level <= 1'b0;
            primed <= 1'b0;
            rise_out <= 1'b0;
            fall_out <= 1'b0;
        end
        else
        begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
            // First agreement only loads the level, from the reset zeros of s2 and s3,
            // so a pin that is high out of reset still gives a rise pulse
            if (agree)
            begin
                level <= s3;
                primed <= 1'b1;
            end
            rise_out <= agree & primed & s3 & ~level;
            fall_out <= agree & primed & ~s3 & level;
        end
    end
endmodule

/* File: hw/tpg_timer.sv */
// 16-bit pulse generator, one-shot and capture timer with an APB slave.
// Assumes an APB master on core_clk_in and asynchronous input pins.
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module tpg_timer
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Timer pins
    input wire logic input_pin_a_in,
    input wire logic input_pin_b_in,
    output logic timer_out_pin_out,
    // Event pulses
    output logic irq_match_a_out,
    output logic irq_match_b_out
);
    logic [7:0] mode_ctrl_reg;
    logic overflow_flag;
    logic [7:0] output_ctrl_reg;
    logic [7:0] capc_reg;
    logic [15:0] prescale_reg;
    logic [15:0] count_reg;
    logic [15:0] cmp_cap_reg_a;
    logic [15:0] cmp_cap_reg_b;
    logic [7:0] pre_cnt;
    logic out_level;
    logic os_active;
    logic os_half;

    logic rise_a, fall_a, rise_b, fall_b;
    logic apb_take, wr, addr_ok;
    logic [1:0] mode;
    logic running, tick, os_mode, sw_trig, os_trig, clear_now;
    logic valid_a, opp_a, valid_b;
    logic match_a, match_b, cap_a_evt, cap_b_evt;
    logic tog_a, tog_b, ovf_set, ovf_clr, lvl_write;
    logic next_level, next_irq_a, next_irq_b;
    logic [31:0] rdata;

    tpg_edge_sync u_sync_a
    (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .pin_in(input_pin_a_in),
        .rise_out(rise_a),
        .fall_out(fall_a)
    );

    tpg_edge_sync u_sync_b
    (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .pin_in(input_pin_b_in),
        .rise_out(rise_b),
        .fall_out(fall_b)
    );

    // One wait state: pready rises in the second access cycle
    assign apb_take = psel_in & penable_in & pready_out;
    assign wr = apb_take & pwrite_in;
    assign addr_ok = (paddr_in == tpg_pkg::ADDR_MODE)
        | (paddr_in == tpg_pkg::ADDR_OUTC)
        | (paddr_in == tpg_pkg::ADDR_CAPC)
        | (paddr_in == tpg_pkg::ADDR_PRESC)
        | (paddr_in == tpg_pkg::ADDR_COUNT)
        | (paddr_in == tpg_pkg::ADDR_CMPA)
        | (paddr_in == tpg_pkg::ADDR_CMPB);

    assign mode = mode_ctrl_reg[tpg_pkg::MODE_HI_BIT:tpg_pkg::MODE_LO_BIT];
    assign running = (mode != tpg_pkg::MODE_STOP);
    assign tick = running
        & (pre_cnt == prescale_reg[tpg_pkg::DIV_LO +: 8]);

    // Edge select: 00 falling, 01 rising, otherwise both
    always_comb
    begin
        unique case (prescale_reg[tpg_pkg::ES_A_LO +: 2])
            2'b00:
            begin
                valid_a = fall_a;
                opp_a = rise_a;
            end
            2'b01:
            begin
                valid_a = rise_a;
                opp_a = fall_a;
            end
            default:
            begin
                valid_a = rise_a | fall_a;
                opp_a = 1'b0;
            end
        endcase
        unique case (prescale_reg[tpg_pkg::ES_B_LO +: 2])
            2'b00: valid_b = fall_b;
            2'b01: valid_b = rise_b;
            default: valid_b = rise_b | fall_b;
        endcase
    end

    assign os_mode = output_ctrl_reg[tpg_pkg::OS_EN_BIT]
        & ((mode == tpg_pkg::MODE_FREE)
        | (mode == tpg_pkg::MODE_EDGE_CLR));
    assign sw_trig = wr & (paddr_in == tpg_pkg::ADDR_OUTC)
        & pwdata_in[tpg_pkg::OS_TRIG_BIT] & os_mode;
    assign os_trig = sw_trig | (os_mode & valid_a);

    assign match_a = tick & ~capc_reg[tpg_pkg::A_CAP_BIT]
        & (count_reg == cmp_cap_reg_a);
    assign match_b = tick & ~capc_reg[tpg_pkg::B_CAP_BIT]
        & (count_reg == cmp_cap_reg_b);

    assign clear_now = os_trig
        | ((mode == tpg_pkg::MODE_EDGE_CLR) & valid_a)
        | (tick & (mode == tpg_pkg::MODE_MATCH_CLR)
        & (count_reg == cmp_cap_reg_a));

    // Capture A from edge B or from the opposite edge of A
    assign cap_a_evt = running & capc_reg[tpg_pkg::A_CAP_BIT]
        & (capc_reg[tpg_pkg::A_OPP_BIT] ? opp_a : valid_b);
    assign cap_b_evt = running & capc_reg[tpg_pkg::B_CAP_BIT]
        & valid_a;

    // Edge B still signals A when A is fed from pin A's opposite edge
    assign next_irq_a = match_a
        | (running & capc_reg[tpg_pkg::A_CAP_BIT] & valid_b);
    assign next_irq_b = match_b | cap_b_evt;

    // In one-shot use only the two matches after a trigger invert the pin
    assign tog_a = match_a & output_ctrl_reg[tpg_pkg::TOG_A_BIT]
        & (~os_mode | os_active);
    assign tog_b = match_b & output_ctrl_reg[tpg_pkg::TOG_B_BIT]
        & (~os_mode | os_active);

    assign ovf_set = tick & (count_reg == tpg_pkg::COUNT_MAX)
        & ~clear_now & (mode != tpg_pkg::MODE_MATCH_CLR);
    assign ovf_clr = wr & (paddr_in == tpg_pkg::ADDR_MODE)
        & ~pwdata_in[tpg_pkg::MODE_OVF_BIT];
    assign lvl_write = wr & (paddr_in == tpg_pkg::ADDR_OUTC) & ~running;

    always_comb
    begin
        next_level = out_level;
        if (lvl_write)
        begin
            unique case ({pwdata_in[tpg_pkg::LVL_SET_BIT],
                          pwdata_in[tpg_pkg::LVL_CLR_BIT]})
                2'b10: next_level = 1'b1;
                2'b01: next_level = 1'b0;
                default: next_level = out_level;
            endcase
        end
        else if (tog_a ^ tog_b)
        begin
            next_level = ~out_level;
        end
    end

    always_comb
    begin
        rdata = 32'h0000_0000;
        unique case (paddr_in)
            tpg_pkg::ADDR_MODE:
                rdata[7:0] = mode_ctrl_reg | {7'h00, overflow_flag};
            tpg_pkg::ADDR_OUTC: rdata[7:0] = output_ctrl_reg;
            tpg_pkg::ADDR_CAPC: rdata[7:0] = capc_reg;
            tpg_pkg::ADDR_PRESC: rdata[15:0] = prescale_reg;
            tpg_pkg::ADDR_COUNT: rdata[15:0] = count_reg;
            tpg_pkg::ADDR_CMPA: rdata[15:0] = cmp_cap_reg_a;
            tpg_pkg::ADDR_CMPB: rdata[15:0] = cmp_cap_reg_b;
            default: rdata = 32'h0000_0000;
        endcase
    end

    // APB answer
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            pready_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
            pslverr_out <= 1'b0;
        end
        else if (psel_in & penable_in & ~pready_out)
        begin
            pready_out <= 1'b1;
            prdata_out <= (addr_ok & ~pwrite_in) ? rdata : 32'h0000_0000;
            pslverr_out <= ~addr_ok;
        end
        else
        begin
            pready_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
            pslverr_out <= 1'b0;
        end
    end

    // Control registers
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            mode_ctrl_reg <= tpg_pkg::CTRL_RST;
            output_ctrl_reg <= tpg_pkg::CTRL_RST;
            capc_reg <= tpg_pkg::CTRL_RST;
            prescale_reg <= tpg_pkg::WORD_RST;
        end
        else if (wr)
        begin
            unique case (paddr_in)
                tpg_pkg::ADDR_MODE:
                    mode_ctrl_reg <= pwdata_in[7:0] & tpg_pkg::MODE_WMASK;
                tpg_pkg::ADDR_OUTC:
                    output_ctrl_reg <= pwdata_in[7:0] & tpg_pkg::OUTC_WMASK;
                tpg_pkg::ADDR_CAPC:
                    capc_reg <= pwdata_in[7:0] & tpg_pkg::CAPC_WMASK;
                tpg_pkg::ADDR_PRESC:
                    prescale_reg <= pwdata_in[15:0] & tpg_pkg::PRESC_WMASK;
                default:
                begin
                end
            endcase
        end
    end

    // Overflow: hardware set wins over a software clear
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
            overflow_flag <= 1'b0;
        else if (ovf_set)
            overflow_flag <= 1'b1;
        else if (ovf_clr)
            overflow_flag <= 1'b0;
    end

    // Prescaler and counter
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in | ~running)
        begin
            pre_cnt <= 8'h00;
            count_reg <= tpg_pkg::WORD_RST;
        end
        else
        begin
            pre_cnt <= (tick | clear_now) ? 8'h00 : pre_cnt + 8'h01;
            if (clear_now)
                count_reg <= tpg_pkg::WORD_RST;
            else if (tick)
                count_reg <= count_reg + 16'h0001;
        end
    end

    // Compare/capture registers: capture beats a software write
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            cmp_cap_reg_a <= tpg_pkg::WORD_RST;
            cmp_cap_reg_b <= tpg_pkg::WORD_RST;
        end
        else
        begin
            if (cap_a_evt)
                cmp_cap_reg_a <= count_reg;
            else if (wr & (paddr_in == tpg_pkg::ADDR_CMPA))
                cmp_cap_reg_a <= pwdata_in[15:0];
            if (cap_b_evt)
                cmp_cap_reg_b <= count_reg;
            else if (wr & (paddr_in == tpg_pkg::ADDR_CMPB))
                cmp_cap_reg_b <= pwdata_in[15:0];
        end
    end

    // One-shot progress: armed by a trigger, done after two cycles with a toggle match
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in | ~os_mode)
        begin
            os_active <= 1'b0;
            os_half <= 1'b0;
        end
        else if (os_trig)
        begin
            os_active <= 1'b1;
            os_half <= 1'b0;
        end
        else if (tog_a | tog_b)
        begin
            os_half <= ~os_half;
            os_active <= ~os_half;
        end
    end

    // Pin and event outputs
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            out_level <= 1'b0;
            timer_out_pin_out <= 1'b0;
            irq_match_a_out <= 1'b0;
            irq_match_b_out <= 1'b0;
        end
        else
        begin
            out_level <= next_level;
            timer_out_pin_out <= output_ctrl_reg[tpg_pkg::OUT_EN_BIT]
                & next_level;
            irq_match_a_out <= next_irq_a;
            irq_match_b_out <= next_irq_b;
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    property p_restart;
        tick && mode == tpg_pkg::MODE_MATCH_CLR
            && count_reg == cmp_cap_reg_a |=> count_reg == 16'h0000;
    endproperty
    a_restart: assert property (p_restart)
        else $error("counter not restarted on match A");

    property p_period_bound;
        mode == tpg_pkg::MODE_MATCH_CLR && count_reg <= cmp_cap_reg_a
            && !wr && !$past(wr) |=> count_reg <= cmp_cap_reg_a;
    endproperty
    a_period_bound: assert property (p_period_bound)
        else $error("counter ran past register A");

    property p_duty_edge;
        match_b && output_ctrl_reg[tpg_pkg::TOG_B_BIT] && !os_mode
            && !match_a |=> out_level != $past(out_level);
    endproperty
    a_duty_edge: assert property (p_duty_edge)
        else $error("output not inverted on match B");

    property p_irq_a;
        running && tick && !capc_reg[tpg_pkg::A_CAP_BIT]
            && count_reg == cmp_cap_reg_a |=> irq_match_a_out;
    endproperty
    a_irq_a: assert property (p_irq_a)
        else $error("interrupt A missing on match");

    property p_irq_b_count;
        match_b && !clear_now |=> irq_match_b_out
            && count_reg == $past(count_reg) + 16'h0001;
    endproperty
    a_irq_b_count: assert property (p_irq_b_count)
        else $error("match B did not raise B or stopped count");

    property p_sw_trig;
        sw_trig |=> count_reg == 16'h0000 && os_active;
    endproperty
    a_sw_trig: assert property (p_sw_trig)
        else $error("software trigger did not restart counter");

    property p_edge_clear;
        mode == tpg_pkg::MODE_EDGE_CLR && valid_a
            && capc_reg[tpg_pkg::B_CAP_BIT] |=> count_reg == 16'h0000
            && cmp_cap_reg_b == $past(count_reg);
    endproperty
    a_edge_clear: assert property (p_edge_clear)
        else $error("valid edge did not capture B and clear");

    property p_ovf_hold;
        overflow_flag && !ovf_clr |=> overflow_flag;
    endproperty
    a_ovf_hold: assert property (p_ovf_hold)
        else $error("overflow flag dropped without clear");

    property p_wrap;
        tick && mode == tpg_pkg::MODE_FREE && !clear_now
            && count_reg == tpg_pkg::COUNT_MAX |=> count_reg == 16'h0000
            && overflow_flag;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("wrap did not set overflow");

    property p_opp_no_irq;
        cap_a_evt && capc_reg[tpg_pkg::A_OPP_BIT] && !valid_b
            |=> !irq_match_a_out && cmp_cap_reg_a == $past(count_reg);
    endproperty
    a_opp_no_irq: assert property (p_opp_no_irq)
        else $error("opposite edge capture raised interrupt A");

    property p_stopped;
        !running ##1 !running |-> count_reg == 16'h0000 [*2];
    endproperty
    a_stopped: assert property (p_stopped)
        else $error("counter moved while stopped");

    c_ppg: cover property (match_b && mode == tpg_pkg::MODE_MATCH_CLR);
    c_oneshot: cover property (os_trig ##[1:200] (os_active && tog_b));
    c_wrap: cover property (ovf_set);
    c_capture: cover property (cap_a_evt && cap_b_evt);
endmodule

/* File: testbench/tpg_pin_model.sv */
// Far-side model: drives the two timer input pins and loads the output.
// Assumes the bench calls its task from one process, just after an edge.
`timescale 1ns/1ps
module tpg_pin_model
(
    // Clock
    input wire logic core_clk_in,
    // Timer output load
    input wire logic timer_out_pin_in,
    // Input pin drivers
    output logic input_pin_a_out,
    output logic input_pin_b_out
);
    int rise_count = 0;
    int run = 0;
    int last_high = 0;
    logic last_out = 1'b0;

    initial
    begin
        input_pin_a_out = 1'b0;
        input_pin_b_out = 1'b0;
    end

    // Width of the last finished high pulse, in clocks
    always @(posedge core_clk_in)
    begin
        last_out <= timer_out_pin_in;
        if (timer_out_pin_in === 1'b1)
            run <= (last_out === 1'b1) ? run + 1 : 1;
        else if (last_out === 1'b1)
            last_high <= run;
        if (timer_out_pin_in === 1'b1 && last_out !== 1'b1)
            rise_count <= rise_count + 1;
    end

    // Pins move only on command, then hold for n clocks
    task automatic set_pins(input logic a, input logic b, input int n);
        input_pin_a_out <= a;
        input_pin_b_out <= b;
        repeat (n) @(posedge core_clk_in);
    endtask
endmodule

/* File: testbench/test_timer_pulse_gen_capture.sv */
// Self-checking bench for the pulse generator and capture timer.
// Assumes tpg_timer and tpg_pin_model; registers are reached over APB.
`timescale 1ns/1ps
`define CHK(what, exp, got) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            bad_count++; \
            $display("mismatch %s expected %0h seen %0h", what, exp, got); \
        end \
    end
module test_timer_pulse_gen_capture;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic input_pin_a_in;
    logic input_pin_b_in;
    logic timer_out_pin_out;
    logic irq_match_a_out;
    logic irq_match_b_out;
    logic [31:0] rd;
    logic err;
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;
    int cnt_a = 0;
    int cnt_b = 0;
    int last_a = 0;
    int prev_a = 0;
    int last_b = 0;
    int prev_b = 0;

    tpg_timer tpg_timer_i (
        .core_clk_in(core_clk_in), .rst_in(rst_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out),
        .input_pin_a_in(input_pin_a_in), .input_pin_b_in(input_pin_b_in),
        .timer_out_pin_out(timer_out_pin_out),
        .irq_match_a_out(irq_match_a_out), .irq_match_b_out(irq_match_b_out)
    );

    tpg_pin_model tpg_pin_model_i (
        .core_clk_in(core_clk_in), .timer_out_pin_in(timer_out_pin_out),
        .input_pin_a_out(input_pin_a_in), .input_pin_b_out(input_pin_b_in)
    );

    initial
    begin
        forever #2.5 core_clk_in = ~core_clk_in;
    end

    // Cycle stamps of the event pulses, for spacing checks
    always @(posedge core_clk_in)
    begin
        cyc <= cyc + 1;
        if (irq_match_a_out === 1'b1)
        begin
            cnt_a <= cnt_a + 1;
            prev_a <= last_a;
            last_a <= cyc;
        end
        if (irq_match_b_out === 1'b1)
        begin
            cnt_b <= cnt_b + 1;
            prev_b <= last_b;
            last_b <= cyc;
        end
    end

    // Request held until pready is seen at an edge; only the watchdog
    // cuts a slave that never answers
    task automatic apb(input logic wr, input logic [7:0] addr,
                       input logic [31:0] wd);
        @(posedge core_clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= addr;
        pwdata_in <= wd;
        @(posedge core_clk_in);
        penable_in <= 1'b1;
        do
            @(posedge core_clk_in);
        while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
        apb(1'b1, addr, wd);
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp,
                          input string what);
        apb(1'b0, addr, 32'h0);
        `CHK(what, exp, rd)
    endtask

    task automatic test_regs();
        for (int i = 0; i < 7; i++)
            rd_chk(8'(4 * i), 32'h0, "reset value");
        apb(1'b0, 8'h1c, 32'h0);
        `CHK("unmapped error", 1'b1, err)
        `CHK("unmapped data", 32'h0, rd)
        wr(tpg_pkg::ADDR_COUNT, 32'h00001234);
        rd_chk(tpg_pkg::ADDR_COUNT, 32'h0, "count stopped");
        wr(tpg_pkg::ADDR_CMPA, 32'h0000abcd);
        rd_chk(tpg_pkg::ADDR_CMPA, 32'h0000abcd, "cmpa");
        $display("test regs done");
    endtask

    task automatic test_ppg();
        wr(tpg_pkg::ADDR_CMPA, 32'd9);
        wr(tpg_pkg::ADDR_CMPB, 32'd3);
        wr(tpg_pkg::ADDR_OUTC, 32'h09);
        wr(tpg_pkg::ADDR_OUTC, 32'h13);
        wr(tpg_pkg::ADDR_MODE, 32'h0c);
        repeat (60) @(posedge core_clk_in);
        `CHK("period a", 10, last_a - prev_a)
        `CHK("period b", 10, last_b - prev_b)
        `CHK("a after b", 6, ((last_a - last_b) % 10 + 10) % 10)
        `CHK("high width", 4, tpg_pin_model_i.last_high)
        wr(tpg_pkg::ADDR_MODE, 32'h00);
        $display("test ppg done");
    endtask

    task automatic test_oneshot();
        int r0;
        wr(tpg_pkg::ADDR_OUTC, 32'h05);
        wr(tpg_pkg::ADDR_CMPA, 32'd5);
        wr(tpg_pkg::ADDR_CMPB, 32'd12);
        wr(tpg_pkg::ADDR_OUTC, 32'h33);
        wr(tpg_pkg::ADDR_PRESC, 32'h10);
        wr(tpg_pkg::ADDR_MODE, 32'h04);
        repeat (40) @(posedge core_clk_in);
        r0 = tpg_pin_model_i.rise_count;
        wr(tpg_pkg::ADDR_OUTC, 32'h73);
        repeat (100) @(posedge core_clk_in);
        `CHK("one pulse", r0 + 1, tpg_pin_model_i.rise_count)
        `CHK("shot width", 7, tpg_pin_model_i.last_high)
        `CHK("b after a", 7, last_b - last_a)
        // Next trigger only once the pulse is over
        tpg_pin_model_i.set_pins(1'b1, 1'b0, 100);
        `CHK("edge pulse", r0 + 2, tpg_pin_model_i.rise_count)
        `CHK("edge width", 7, tpg_pin_model_i.last_high)
        // One-shot also works in clear-on-edge mode; pin A stays high
        wr(tpg_pkg::ADDR_MODE, 32'h08);
        wr(tpg_pkg::ADDR_OUTC, 32'h73);
        repeat (100) @(posedge core_clk_in);
        `CHK("mode 10 pulse", r0 + 3, tpg_pin_model_i.rise_count)
        `CHK("mode 10 width", 7, tpg_pin_model_i.last_high)
        wr(tpg_pkg::ADDR_MODE, 32'h00);
        $display("test oneshot done");
    endtask

    task automatic test_cap_two();
        int na;
        int nb;
        logic [31:0] ca;
        wr(tpg_pkg::ADDR_OUTC, 32'h00);
        tpg_pin_model_i.set_pins(1'b0, 1'b0, 10);
        wr(tpg_pkg::ADDR_PRESC, 32'ha0);
        wr(tpg_pkg::ADDR_CAPC, 32'h05);
        wr(tpg_pkg::ADDR_MODE, 32'h04);
        na = cnt_a;
        nb = cnt_b;
        tpg_pin_model_i.set_pins(1'b1, 1'b0, 20);
        tpg_pin_model_i.set_pins(1'b1, 1'b1, 20);
        tpg_pin_model_i.set_pins(1'b0, 1'b1, 10);
        apb(1'b0, tpg_pkg::ADDR_CMPA, 32'h0);
        ca = rd;
        apb(1'b0, tpg_pkg::ADDR_CMPB, 32'h0);
        `CHK("b minus a", 16'd20, 16'(rd[15:0] - ca[15:0]))
        `CHK("irq a count", 1, cnt_a - na)
        `CHK("irq b count", 2, cnt_b - nb)
        wr(tpg_pkg::ADDR_MODE, 32'h00);
        $display("test two-pin capture done");
    endtask

    task automatic test_cap_one();
        int na;
        int nb;
        logic [31:0] ca;
        tpg_pin_model_i.set_pins(1'b0, 1'b0, 10);
        wr(tpg_pkg::ADDR_PRESC, 32'h10);
        wr(tpg_pkg::ADDR_CAPC, 32'h07);
        wr(tpg_pkg::ADDR_MODE, 32'h08);
        na = cnt_a;
        nb = cnt_b;
        tpg_pin_model_i.set_pins(1'b1, 1'b0, 30);
        tpg_pin_model_i.set_pins(1'b0, 1'b0, 50);
        tpg_pin_model_i.set_pins(1'b1, 1'b0, 10);
        apb(1'b0, tpg_pkg::ADDR_CMPA, 32'h0);
        ca = rd;
        apb(1'b0, tpg_pkg::ADDR_CMPB, 32'h0);
        `CHK("low width", 16'd50, 16'(rd[15:0] - ca[15:0]))
        `CHK("cycle", 1'b1, rd >= 79 && rd <= 81)
        `CHK("no irq a", 0, cnt_a - na)
        `CHK("irq b count", 2, cnt_b - nb)
        wr(tpg_pkg::ADDR_MODE, 32'h00);
        wr(tpg_pkg::ADDR_CAPC, 32'h00);
        $display("test one-pin capture done");
    endtask

    task automatic test_overflow();
        rd_chk(tpg_pkg::ADDR_COUNT, 32'h0, "count held");
        wr(tpg_pkg::ADDR_MODE, 32'h04);
        repeat (65600) @(posedge core_clk_in);
        rd_chk(tpg_pkg::ADDR_MODE, 32'h05, "overflow set");
        apb(1'b0, tpg_pkg::ADDR_COUNT, 32'h0);
        `CHK("wrapped", 1'b1, rd < 32'd200)
        rd_chk(tpg_pkg::ADDR_MODE, 32'h05, "overflow held");
        wr(tpg_pkg::ADDR_MODE, 32'h04);
        rd_chk(tpg_pkg::ADDR_MODE, 32'h04, "overflow clear");
        wr(tpg_pkg::ADDR_MODE, 32'h00);
        $display("test overflow done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        repeat (3) @(posedge core_clk_in);
        rst_in <= 1'b0;
        test_regs();
        test_ppg();
        test_oneshot();
        test_cap_two();
        test_cap_one();
        test_overflow();
        tally_and_finish();
    end

    // The run needs about 66400 clocks, most of it waiting for the wrap
    initial
    begin
        repeat (80000) @(posedge core_clk_in);
        bad_count++;
        tally_and_finish();
    end
endmodule
